// File: core/cmpi_pkg.sv
// Purpose: Shared constants and types for the comparator interrupt block
// Assumes: Single clock, 8-bit register port
// Notes:   Register offsets are indices on the plain register port
package cmpi_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [3:0] OFS_SYSTEM_CONTROL_ZERO = 4'h0;
    localparam logic [3:0] OFS_INTC  = 4'h1;
    localparam logic [3:0] OFS_FLAGS = 4'h2;
    localparam logic [3:0] OFS_CMPEN = 4'h3;
    localparam logic [3:0] OFS_CAUSE = 4'h4;
    // Control register zero fields
    localparam int unsigned B_LVD_EN   = 0;
    localparam int unsigned B_LVD_STAT = 1;
    localparam int unsigned B_PRESC    = 3;
    localparam int unsigned B_TMR_SEL  = 6;
    localparam int unsigned B_C2_INV   = 7;
    localparam logic [7:0]  SYSTEM_CONTROL_ZERO_RST  = 8'h00;
    localparam logic [7:0]  SYSTEM_CONTROL_ZERO_WMSK = 8'hc9;
    // Interrupt control fields
    localparam int unsigned B_GIE = 0;
    localparam int unsigned B_C1E = 1;
    localparam int unsigned B_MFE = 2;
    localparam int unsigned B_MFF = 3;
    localparam int unsigned B_LVE = 4;
    // Flag register fields
    localparam int unsigned B_C1F = 0;
    localparam int unsigned B_C2F = 1;
    localparam int unsigned B_C3F = 2;
    localparam int unsigned B_T1F = 3;
    localparam int unsigned B_LVF = 4;
    // Comparator enable fields
    localparam int unsigned B_C2E = 0;
    localparam int unsigned B_C3E = 1;
    localparam int unsigned B_T1E = 2;
    // Vectors
    localparam logic [7:0] VEC_MULTI = 8'h04;
    localparam logic [7:0] VEC_LVD   = 8'h0c;
    localparam logic [7:0] VEC_CMP1  = 8'h10;
    localparam int unsigned LVD_MILLIVOLT = 4400;
    localparam int unsigned SYNC_STAGES   = 3;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmpi_bus_t;

    typedef struct packed {
        logic       req;
        logic [7:0] vector;
    } cmpi_irq_t;
endpackage

// File: core/cmpi_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous input bits
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module cmpi_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    dout[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // cmpi_sync
`default_nettype wire

// File: core/cmpi_top.sv
// Purpose: Comparator interrupt requests, wake-up and low-supply detector control
// Assumes: Core acknowledges a vector with a one-cycle service pulse
// Notes:   Comparator outputs and detector output are asynchronous
// Operation
// - Comparator one own vector; two, three shared
// - Comparator one flag set on any change
// - Vector one needs enables, stack room, flag
// - Service one clears its flag and global enable
// - Comparator two/three flags set on change
// - Shared vector needs global, shared, source enables
// - Shared service clears global and summary only
// - Any rising request flag except timer one's wakes from power-down
// - Wake-up ignores every enable bit
// - Flags hold until serviced or software clears
// - Entry pushes only program counter
// - Detector usable only when option enables it
// - Detector enable at control bit zero
// - Detector status at control bit one
// - Low supply reported below 4.4 volts
// - Detector forced off during power-down
// - Summary flag set by comparator two/three change or timer one overflow
// - Shared vector address is 04H
// - Low-supply flag set when option selects it
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cmpi_top #(
    parameter bit LVD_OPTION = 1'b1,
    parameter bit LVD_IRQ_OPTION = 1'b1
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire cmpi_pkg::cmpi_bus_t  bus,
    output logic [7:0]                rdata,
    input  wire logic [2:0]           cmp_out,
    input  wire logic                 timer1_ovf,
    input  wire logic                 low_supply_raw,
    input  wire logic                 power_down,
    input  wire logic                 stack_full,
    input  wire logic                 service,
    output var cmpi_pkg::cmpi_irq_t   irq,
    output logic                      push_pc_only,
    output logic                      wake_up,
    output logic                      low_supply_detect_on
);
    logic [7:0] system_control_zero_r;
    logic       global_irq_enable_r;
    logic       cmp_one_irq_enable_r;
    logic       multi_source_irq_enable_r;
    logic       low_supply_irq_enable_r;
    logic       cmp_two_irq_enable_r;
    logic       cmp_three_irq_enable_r;
    logic       timer1_irq_enable_r;
    logic       cmp_one_req_flag_r;
    logic       cmp_two_req_flag_r;
    logic       cmp_three_req_flag_r;
    logic       timer1_req_flag_r;
    logic       ext_or_low_supply_req_flag_r;
    logic       multi_source_req_flag_r;
    logic [2:0] cmp_prev_r;
    logic       low_prev_r;
    logic [4:0] flags_prev_r;
    logic [7:0] last_vec_r;
    logic [2:0] cmp_sync;
    logic       low_sync;
    logic [2:0] cmp_change;
    logic       low_rise;
    logic       low_supply_status;
    logic       take_one;
    logic       take_multi;
    logic       take_lvd;
    logic       req_one;
    logic       req_multi;
    logic       req_lvd;
    logic [4:0] flags_now;
    logic       wr_intc;
    logic       wr_flags;
    logic       wr_cmpen;
    logic       wr_system_control_zero;
    logic       accept;
    logic [4:0] flags_rise;
    logic [7:0] rdata_nxt;

    cmpi_sync #(
        .W (4)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .din     ({low_supply_raw, cmp_out}),
        .dout    ({low_sync, cmp_sync})
    );

    assign wr_intc  = bus.wr && (bus.addr == cmpi_pkg::OFS_INTC);
    assign wr_flags = bus.wr && (bus.addr == cmpi_pkg::OFS_FLAGS);
    assign wr_cmpen = bus.wr && (bus.addr == cmpi_pkg::OFS_CMPEN);
    assign wr_system_control_zero = bus.wr && (bus.addr == cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO);

    // Detector runs only with option, software enable, and awake
    assign low_supply_detect_on = LVD_OPTION && system_control_zero_r[cmpi_pkg::B_LVD_EN] && !power_down;
    // Analog comparator trips at the fixed threshold; digital side sees a level
    assign low_supply_status = low_supply_detect_on && low_sync;

    // Previous synchronised samples for change detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_prev_r <= '0;
        end else begin
            cmp_prev_r <= cmp_sync;
        end
    end

    // Detector status one cycle back, for its rising edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_prev_r <= 1'b0;
        end else begin
            low_prev_r <= low_supply_status;
        end
    end

    assign cmp_change = cmp_sync ^ cmp_prev_r;
    assign low_rise   = low_supply_status && !low_prev_r;

    // Request arbitration: shared, then low supply, then comparator one
    assign req_one   = global_irq_enable_r && cmp_one_irq_enable_r && cmp_one_req_flag_r;
    assign req_multi = global_irq_enable_r && multi_source_irq_enable_r && multi_source_req_flag_r
                       && ((cmp_two_irq_enable_r && cmp_two_req_flag_r)
                       || (cmp_three_irq_enable_r && cmp_three_req_flag_r)
                       || (timer1_irq_enable_r && timer1_req_flag_r));
    assign req_lvd   = global_irq_enable_r && low_supply_irq_enable_r && ext_or_low_supply_req_flag_r;

    always_comb begin
        irq.req    = 1'b0;
        irq.vector = last_vec_r;
        if (!stack_full) begin
            if (req_multi) begin
                irq.req    = 1'b1;
                irq.vector = cmpi_pkg::VEC_MULTI;
            end else if (req_lvd) begin
                irq.req    = 1'b1;
                irq.vector = cmpi_pkg::VEC_LVD;
            end else if (req_one) begin
                irq.req    = 1'b1;
                irq.vector = cmpi_pkg::VEC_CMP1;
            end
        end
    end

    // Core accepts the vector on show
    assign accept     = service && irq.req;
    assign take_multi = accept && (irq.vector == cmpi_pkg::VEC_MULTI);
    assign take_lvd   = accept && (irq.vector == cmpi_pkg::VEC_LVD);
    assign take_one   = accept && (irq.vector == cmpi_pkg::VEC_CMP1);

    // Only the return address is saved by hardware
    assign push_pc_only = accept;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_vec_r <= 8'h00;
        end else if (service && irq.req) begin
            last_vec_r <= irq.vector;
        end
    end

    // Control register zero; status bit is live, read-only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            system_control_zero_r <= cmpi_pkg::SYSTEM_CONTROL_ZERO_RST;
        end else if (wr_system_control_zero) begin
            system_control_zero_r <= bus.wdata & cmpi_pkg::SYSTEM_CONTROL_ZERO_WMSK;
        end
    end

    // Global enable: service clears it, winning over a write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            global_irq_enable_r <= 1'b0;
        end else if (accept) begin
            global_irq_enable_r <= 1'b0;
        end else if (wr_intc) begin
            global_irq_enable_r <= bus.wdata[cmpi_pkg::B_GIE];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_one_irq_enable_r      <= 1'b0;
            multi_source_irq_enable_r <= 1'b0;
            low_supply_irq_enable_r   <= 1'b0;
        end else if (wr_intc) begin
            cmp_one_irq_enable_r      <= bus.wdata[cmpi_pkg::B_C1E];
            multi_source_irq_enable_r <= bus.wdata[cmpi_pkg::B_MFE];
            low_supply_irq_enable_r   <= bus.wdata[cmpi_pkg::B_LVE];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_two_irq_enable_r   <= 1'b0;
            cmp_three_irq_enable_r <= 1'b0;
            timer1_irq_enable_r    <= 1'b0;
        end else if (wr_cmpen) begin
            cmp_two_irq_enable_r   <= bus.wdata[cmpi_pkg::B_C2E];
            cmp_three_irq_enable_r <= bus.wdata[cmpi_pkg::B_C3E];
            timer1_irq_enable_r    <= bus.wdata[cmpi_pkg::B_T1E];
        end
    end

    // Source flags: set wins over clear; enables never clear them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_one_req_flag_r <= 1'b0;
        end else if (cmp_change[0]) begin
            cmp_one_req_flag_r <= 1'b1;
        end else if (take_one) begin
            cmp_one_req_flag_r <= 1'b0;
        end else if (wr_flags) begin
            cmp_one_req_flag_r <= bus.wdata[cmpi_pkg::B_C1F];
        end
    end

    // Shared members: only software clears them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_two_req_flag_r <= 1'b0;
        end else if (cmp_change[1]) begin
            cmp_two_req_flag_r <= 1'b1;
        end else if (wr_flags) begin
            cmp_two_req_flag_r <= bus.wdata[cmpi_pkg::B_C2F];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_three_req_flag_r <= 1'b0;
        end else if (cmp_change[2]) begin
            cmp_three_req_flag_r <= 1'b1;
        end else if (wr_flags) begin
            cmp_three_req_flag_r <= bus.wdata[cmpi_pkg::B_C3F];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer1_req_flag_r <= 1'b0;
        end else if (timer1_ovf) begin
            timer1_req_flag_r <= 1'b1;
        end else if (wr_flags) begin
            timer1_req_flag_r <= bus.wdata[cmpi_pkg::B_T1F];
        end
    end

    // Low-supply flag, cleared by its own service
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_or_low_supply_req_flag_r <= 1'b0;
        end else if (low_rise && LVD_IRQ_OPTION) begin
            ext_or_low_supply_req_flag_r <= 1'b1;
        end else if (take_lvd) begin
            ext_or_low_supply_req_flag_r <= 1'b0;
        end else if (wr_flags) begin
            ext_or_low_supply_req_flag_r <= bus.wdata[cmpi_pkg::B_LVF];
        end
    end

    // Summary flag: set by any member, cleared by shared service
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            multi_source_req_flag_r <= 1'b0;
        end else begin
            if (wr_intc) begin
                multi_source_req_flag_r <= bus.wdata[cmpi_pkg::B_MFF];
            end
            if (take_multi) begin
                multi_source_req_flag_r <= 1'b0;
            end
            if (cmp_change[1] || cmp_change[2] || timer1_ovf) begin
                multi_source_req_flag_r <= 1'b1;
            end
        end
    end

    // Wake-up on any flag rising except the timer one flag, regardless of enables
    assign flags_now  = {ext_or_low_supply_req_flag_r, multi_source_req_flag_r,
                         cmp_three_req_flag_r, cmp_two_req_flag_r, cmp_one_req_flag_r};
    assign flags_rise = flags_now & ~flags_prev_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_prev_r <= '0;
        end else begin
            flags_prev_r <= flags_now;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_up <= 1'b0;
        end else begin
            wake_up <= power_down && |flags_rise;
        end
    end

    // Register read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO: begin
                    rdata_nxt = system_control_zero_r | ({7'h00, low_supply_status} << cmpi_pkg::B_LVD_STAT);
                end
                cmpi_pkg::OFS_INTC: begin
                    rdata_nxt = {3'h0, low_supply_irq_enable_r, multi_source_req_flag_r,
                                 multi_source_irq_enable_r, cmp_one_irq_enable_r, global_irq_enable_r};
                end
                cmpi_pkg::OFS_FLAGS: begin
                    rdata_nxt = {3'h0, ext_or_low_supply_req_flag_r, timer1_req_flag_r,
                                 cmp_three_req_flag_r, cmp_two_req_flag_r, cmp_one_req_flag_r};
                end
                cmpi_pkg::OFS_CMPEN: begin
                    rdata_nxt = {5'h00, timer1_irq_enable_r, cmp_three_irq_enable_r, cmp_two_irq_enable_r};
                end
                cmpi_pkg::OFS_CAUSE: begin
                    rdata_nxt = last_vec_r;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // Read data stands one cycle after the strobe, else zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_nxt;
        end
    end
endmodule // cmpi_top
`default_nettype wire

// File: tb/cmpi_checker.sv
// Purpose: Port-level assertions for the comparator interrupt block
// Assumes: Enable bits mirrored from register writes
// Notes:   Bound to every cmpi_top instance
`timescale 1ns/1ns
`default_nettype none
module cmpi_checker #(
    parameter bit LVD_OPTION = 1'b1
) (
    input wire logic                clk,
    input wire logic                reset_n,
    input wire cmpi_pkg::cmpi_bus_t bus,
    input wire logic [7:0]          rdata,
    input wire logic                power_down,
    input wire logic                stack_full,
    input wire logic                service,
    input wire cmpi_pkg::cmpi_irq_t irq,
    input wire logic                push_pc_only,
    input wire logic                wake_up,
    input wire logic                low_supply_detect_on
);
    logic [7:0] intc_r;
    logic       lvd_en_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Mirror of interrupt enables, service drops global
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intc_r <= 8'h00;
        end else begin
            if (bus.wr && bus.addr == cmpi_pkg::OFS_INTC) begin
                intc_r <= bus.wdata;
            end
            if (service && irq.req) begin
                intc_r[cmpi_pkg::B_GIE] <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lvd_en_r <= 1'b0;
        end else if (bus.wr && bus.addr == cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO) begin
            lvd_en_r <= bus.wdata[cmpi_pkg::B_LVD_EN];
        end
    end
    pc_push_only_a: assert property (push_pc_only == (service && irq.req))
        else $error("push flag differs from accepted service");
    stack_blocks_a: assert property (stack_full |-> !irq.req)
        else $error("request with full stack");
    req_needs_global_a: assert property (irq.req |-> intc_r[cmpi_pkg::B_GIE])
        else $error("request without global enable");
    cmp1_enable_a: assert property (irq.req && irq.vector == cmpi_pkg::VEC_CMP1 |-> intc_r[cmpi_pkg::B_C1E])
        else $error("comparator one vector while disabled");
    shared_enable_a: assert property (irq.req && irq.vector == cmpi_pkg::VEC_MULTI |-> intc_r[cmpi_pkg::B_MFE])
        else $error("shared vector while disabled");
    vector_legal_a: assert property (irq.req |-> irq.vector inside {8'h04, 8'h0c, 8'h10})
        else $error("illegal vector");
    service_drops_a: assert property (service && irq.req && !bus.wr |=> !irq.req)
        else $error("request survives service");
    pd_detector_off_a: assert property (power_down |-> !low_supply_detect_on)
        else $error("detector on in power-down");
    detector_follows_a: assert property (!power_down |-> low_supply_detect_on == (lvd_en_r && LVD_OPTION))
        else $error("detector power differs from enable");
    wake_needs_pd_a: assert property (!power_down |=> !wake_up)
        else $error("wake-up outside power-down");
    ctrl_unused_zero_a: assert property (bus.rd && bus.addr == cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO |=> rdata[5:4] == 2'h0 && !rdata[2])
        else $error("unused control bits read nonzero");
endmodule // cmpi_checker
bind cmpi_top cmpi_checker #(.LVD_OPTION(LVD_OPTION)) chk_i (
    .clk, .reset_n, .bus, .rdata, .power_down, .stack_full,
    .service, .irq, .push_pc_only, .wake_up, .low_supply_detect_on
);
`default_nettype wire

// File: tb/cmpi_core_model.sv
// Purpose: Core sequencer answering vector requests
// Assumes: One service pulse per taken request
// Notes:   Lag sets the answer delay in cycles
`timescale 1ns/1ns
`default_nettype none
module cmpi_core_model (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire cmpi_pkg::cmpi_irq_t irq,
    input  wire logic [1:0]          lag,
    output logic                     service
);
    logic [1:0] wait_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r  <= 2'h0;
            service <= 1'b0;
        end else if (service || !irq.req) begin
            wait_r  <= 2'h0;
            service <= 1'b0;
        end else if (wait_r == lag) begin
            service <= 1'b1;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule // cmpi_core_model
`default_nettype wire

// File: tb/cmpi_top_bench.sv
// Purpose: Self-checking bench for the comparator interrupt block
// Assumes: Core model answers after a random lag
// Notes:   Seeded xorshift picks sources, lags and control values
`timescale 1ns/1ns
`default_nettype none
module cmpi_top_bench;
    logic                clk = 1'b0;
    logic                reset_n;
    cmpi_pkg::cmpi_bus_t bus;
    logic [7:0]          rdata;
    logic [2:0]          cmp_out;
    logic                timer1_ovf;
    logic                low_supply_raw;
    logic                power_down;
    logic                stack_full;
    logic                service;
    cmpi_pkg::cmpi_irq_t irq;
    logic                push_pc_only;
    logic                wake_up;
    logic                low_supply_detect_on;
    logic [1:0]          lag;
    logic [31:0]         seed = 32'h43a2;
    logic [7:0]          last_vec;
    int                  fails = 0;
    int                  checks_done = 0;
    int                  svc = 0;
    int                  wakes = 0;

    always #5 clk = ~clk;

    cmpi_top uut (
        .clk, .reset_n, .bus, .rdata, .cmp_out, .timer1_ovf, .low_supply_raw,
        .power_down, .stack_full, .service, .irq, .push_pc_only, .wake_up,
        .low_supply_detect_on
    );
    cmpi_core_model core (.clk, .reset_n, .irq, .lag, .service);

    always @(negedge clk) begin
        if (push_pc_only === 1'b1) begin
            svc++;
            last_vec = irq.vector;
        end
        if (wake_up === 1'b1) begin
            wakes++;
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] exp_flg(input int s, input bit pend);
        return (pend || s != 0) ? 8'h01 << s : 8'h00;
    endfunction
    // Unused bits and status read zero with a healthy supply
    function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
        return v & 8'hc9;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic tgl(input int i);
        @(posedge clk);
        cmp_out[i] <= ~cmp_out[i];
    endtask
    task automatic wait_svc(input int n, input logic [7:0] v);
        for (int k = 0; k < 40 && svc == n; k++) begin
            @(posedge clk);
        end
        chk(8'(svc - n), 8'h01);
        chk(last_vec, v);
    endtask
    task automatic irq_run(input int s, input bit blk);
        int n;
        logic [7:0] d;
        wr(cmpi_pkg::OFS_CMPEN, 8'h03);
        wr(cmpi_pkg::OFS_INTC, s == 0 ? 8'h03 : 8'h05);
        stack_full <= blk;
        n = svc;
        tgl(s);
        if (blk) begin
            repeat (12) @(posedge clk);
            chk(8'(svc - n), 8'h00);
            rd(cmpi_pkg::OFS_FLAGS, d);
            chk(d, exp_flg(s, 1'b1));
            stack_full <= 1'b0;
        end
        wait_svc(n, s == 0 ? cmpi_pkg::VEC_CMP1 : cmpi_pkg::VEC_MULTI);
        rd(cmpi_pkg::OFS_FLAGS, d);
        chk(d, exp_flg(s, 1'b0));
        rd(cmpi_pkg::OFS_INTC, d);
        chk(d, s == 0 ? 8'h02 : 8'h04);
        wr(cmpi_pkg::OFS_FLAGS, 8'h00);
        rd(cmpi_pkg::OFS_FLAGS, d);
        chk(d, 8'h00);
    endtask
    task automatic results();
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end

    initial begin
        logic [7:0] d;
        logic [31:0] r;
        int n;
        reset_n <= 1'b0;
        bus <= '0;
        cmp_out <= 3'h0;
        timer1_ovf <= 1'b0;
        low_supply_raw <= 1'b0;
        power_down <= 1'b0;
        stack_full <= 1'b0;
        lag <= 2'h0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, d);
        chk(d, 8'h00);
        rd(4'hf, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 32'hff : xs();
            wr(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, r[7:0]);
            rd(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, d);
            chk(d, exp_ctrl(r[7:0]));
        end
        wr(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, 8'h01);
        repeat (10) @(posedge clk);
        wr(cmpi_pkg::OFS_FLAGS, 8'h00);
        low_supply_raw <= 1'b1;
        repeat (10) @(posedge clk);
        rd(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, d);
        chk(d, 8'h03);
        rd(cmpi_pkg::OFS_FLAGS, d);
        chk(d, 8'h10);
        wr(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, 8'h00);
        repeat (10) @(posedge clk);
        rd(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, d);
        chk(d, 8'h00);
        low_supply_raw <= 1'b0;
        wr(cmpi_pkg::OFS_FLAGS, 8'h00);
        wr(cmpi_pkg::OFS_INTC, 8'h00);
        @(posedge clk);
        timer1_ovf <= 1'b1;
        @(posedge clk);
        timer1_ovf <= 1'b0;
        rd(cmpi_pkg::OFS_INTC, d);
        chk(d, 8'h08);
        wr(cmpi_pkg::OFS_FLAGS, 8'h00);
        wr(cmpi_pkg::OFS_INTC, 8'h00);
        for (int i = 0; i < 3; i++) begin
            irq_run(i, i != 1);
        end
        for (int i = 0; i < 8; i++) begin
            r = xs();
            lag <= r[1:0];
            irq_run(int'(r[3:2]) % 3, r[4]);
        end
        wr(cmpi_pkg::OFS_SYSTEM_CONTROL_ZERO, 8'h01);
        power_down <= 1'b1;
        n = wakes;
        tgl(0);
        repeat (10) @(posedge clk);
        chk(8'(wakes - n), 8'h01);
        chk({7'h00, low_supply_detect_on}, 8'h00);
        power_down <= 1'b0;
        wr(cmpi_pkg::OFS_FLAGS, 8'h01);
        @(posedge clk);
        power_down <= 1'b1;
        tgl(0);
        repeat (10) @(posedge clk);
        chk(8'(wakes - n), 8'h01);
        power_down <= 1'b0;
        results();
    end
endmodule // cmpi_top_bench
`default_nettype wire
